/* File: rtl/hps_defines.svh */
// Register map, field positions, reset values and timing constants.
`ifndef HPS_DEFINES_SVH
`define HPS_DEFINES_SVH

// Command codes of the register set.
`define HPS_REG_RSVD0    3'h0
`define HPS_REG_RSVD1    3'h1
`define HPS_REG_CTRL_A   3'h2
`define HPS_REG_CTRL_B   3'h3
`define HPS_REG_STAT_A   3'h4
`define HPS_REG_STAT_B   3'h5
`define HPS_REG_COMMON   3'h6
`define HPS_REG_FUNC     3'h7

// Slot control fields.
`define HPS_CT_AUXPG     7
`define HPS_CT_MAINPG    6
`define HPS_CT_INHIB     2
`define HPS_CT_MAINEN    1
`define HPS_CT_AUXEN     0

// Slot status fields.
`define HPS_ST_SUM       7
`define HPS_ST_MAIN      6
`define HPS_ST_AUX       5
`define HPS_ST_AUXF      4
`define HPS_ST_12F       2
`define HPS_ST_3F        0

// Common status fields.
`define HPS_CS_GPI_HI    7
`define HPS_CS_GPI_LO    4
`define HPS_CS_MASK      3
`define HPS_CS_UV        2
`define HPS_CS_OT        1

// Special function fields, reset value and writable bits.
`define HPS_FN_SAFE_B    5
`define HPS_FN_SAFE_A    4
`define HPS_FN_RESET     8'h0d
`define HPS_FN_WMASK     8'hcc

// Fixed upper address bits of the 7-bit bus address.
`define HPS_ADDR_HI      4'h8

// Timing: clock rate and the general input deglitch interval.
`define HPS_CLK_MHZ      200
`define HPS_DGL_MS       5
`define HPS_DGL_CYCLES   (`HPS_DGL_MS * `HPS_CLK_MHZ * 1000)
`define HPS_DGL_W        20

`endif

/* File: rtl/hps_pkg.sv */
// Types shared by the hot plug slot controller files.
package hps_pkg;

  // Conditions reported by the analog part of one slot.
  typedef struct packed {
    logic aux_oc;
    logic rail_twelve_oc;
    logic rail_three_oc;
    logic aux_pg;
    logic main_pg;
    logic aux_supply_uv;
    logic main_uv;
    logic below_low;
    logic thermal_level_one;
  } hps_slot_cond_t;

  // One register write taken from the serial bus.
  typedef struct packed {
    logic [2:0] cmd;
    logic [7:0] data;
  } hps_wr_t;

  // Serial bus slave states.
  typedef enum logic [2:0] {
    S_IDLE, S_ADDR, S_CMD, S_WDATA, S_ACK, S_TX, S_RACK
  } hps_bus_state_t;

endpackage

/* File: rtl/hps_sync.sv */
// Two-stage synchroniser for a group of asynchronous levels.
`timescale 1ns/100ps
`default_nettype none
module hps_sync
  import hps_pkg::*;
#(
  parameter int W = 1
) (
  // Clock and control
  input  wire logic         mclk,
  input  wire logic         resetn,
  input  wire logic         ce,
  // Levels
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_reg;

  // The first stage feeds only the second one.
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      meta_reg <= '0;
      q        <= '0;
    end else if (ce) begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end

endmodule
`default_nettype wire

/* File: rtl/hps_deglitch.sv */
// Deglitch filter: the output follows a level only after it held steady.
`timescale 1ns/100ps
`default_nettype none
`include "hps_defines.svh"
module hps_deglitch
  import hps_pkg::*;
#(
  parameter int CYCLES = `HPS_DGL_CYCLES
) (
  // Clock and control
  input  wire logic mclk,
  input  wire logic resetn,
  input  wire logic ce,
  // Level in and filtered level out
  input  wire logic din,
  output logic      dout
);

  logic [`HPS_DGL_W-1:0] cnt_reg;

  // A level that differs from the output must hold for the whole interval.
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      cnt_reg <= '0;
      dout    <= 1'b0;
    end else if (ce) begin
      if (din == dout) begin
        cnt_reg <= '0;
      end else if (cnt_reg == `HPS_DGL_W'(CYCLES - 1)) begin
        cnt_reg <= '0;
        dout    <= din;
      end else begin
        cnt_reg <= cnt_reg + `HPS_DGL_W'(1);
      end
    end
  end

endmodule
`default_nettype wire

/* File: rtl/hps_ctrl.sv */
// Dual hot plug slot controller: fault latching, modes and serial registers.
//
// Overview of operation
// - Interrupt low on power, undervoltage, overtemperature faults.
// - Direct mode: interrupt follows faults, pins clear.
// - Bus mode: mask bit suppresses interrupt, resets zero.
// - Slot status: summary D7, aux D4, 12V D2, 3V D0.
// - Overcurrent flags stay set until one written.
// - Summary bit read-only, clears when flags clear.
// - Common status: undervoltage D2, overtemperature D1.
// - Written one clears on next read, if gone.
// - Force-on powers slot; aux supply undervoltage still cuts aux.
// - Forced outputs survive level one, die at two.
// - Forced slot shows no fault, no power good.
// - Inhibit bit blocks force-on input, resets zero.
// - General inputs are debounced for bus readback.
// - General input bits follow pins after 5 ms.
// - Safe removal bit set when outputs below threshold.
// - Direct mode: pins switch aux and main outputs.
// - Control write selects bus mode until power cycle.
// - Function writes work in direct mode, no switch.
// - Bus mode: summary fault bit reads inactive.
// - Address: fixed upper bits, straps in low three.
// - Serial clock 10 kHz to 400 kHz supported.
// - Command byte selects register codes 00h to 07h.
`timescale 1ns/100ps
`default_nettype none
`include "hps_defines.svh"
module hps_ctrl
  import hps_pkg::*;
#(
  parameter int DGL_CYCLES = `HPS_DGL_CYCLES
) (
  // Clock, reset and clock enable
  input  wire logic                 mclk,
  input  wire logic                 resetn,
  input  wire logic                 ce,
  // Serial bus pins and address straps
  input  wire logic                 scl,
  input  wire logic                 sda_i,
  output logic                      sda_o,
  output logic                      sda_oe,
  input  wire logic [2:0]           address_straps,
  // Slot control pins, index 0 is slot A
  input  wire logic [1:0]           main_power_pin,
  input  wire logic [1:0]           aux_enable_pin,
  input  wire logic [1:0]           force_on_n,
  input  wire logic [3:0]           general_input,
  // Analog conditions
  input  wire hps_slot_cond_t [1:0] slot_cond,
  input  wire logic                 thermal_level_two,
  // Slot outputs
  output logic [1:0]                aux_on,
  output logic [1:0]                main_on,
  output logic [1:0]                slot_fault_n,
  output logic [1:0]                power_good_out,
  output logic [1:0]                aux_ilim_sel,
  output logic [1:0]                main_ilim_sel,
  output logic                      irq_n
);

  localparam int NS = 34;

  // Synchronised copies of every pin.
  logic [NS-1:0]        raw;
  logic [NS-1:0]        syn;
  logic                 scl_s;
  logic                 sda_s;
  logic [2:0]           straps_s;
  logic [1:0]           mpin_s;
  logic [1:0]           apin_s;
  logic [1:0]           fon_n_s;
  logic [3:0]           gpi_s;
  hps_slot_cond_t [1:0] cond_s;
  logic                 t2_s;
  logic [3:0]           gpi_dg;

  assign raw = {scl, sda_i, address_straps, main_power_pin, aux_enable_pin,
                force_on_n, general_input, slot_cond, thermal_level_two};
  assign {scl_s, sda_s, straps_s, mpin_s, apin_s, fon_n_s, gpi_s, cond_s,
          t2_s} = syn;

  // All pins are asynchronous to mclk; 200 MHz oversamples 400 kHz well.
  hps_sync #(.W(NS)) u_sync (
    .mclk   (mclk),
    .resetn (resetn),
    .ce     (ce),
    .d      (raw),
    .q      (syn)
  );

  // One deglitch filter per general input.
  for (genvar g = 0; g < 4; g++) begin : g_dgl
    hps_deglitch #(.CYCLES(DGL_CYCLES)) u_dgl (
      .mclk   (mclk),
      .resetn (resetn),
      .ce     (ce),
      .din    (gpi_s[g]),
      .dout   (gpi_dg[g])
    );
  end

  // Register state.
  logic                 smbus_mode_reg;
  logic [2:0]           ctrl_reg [2];
  logic                 mask_reg;
  logic [7:0]           func_reg;
  logic [2:0]           flag_reg [2];
  logic [2:0]           echo_st_reg [2];
  logic                 uv_flag_reg;
  logic                 ot_flag_reg;
  logic [1:0]           echo_cs_reg;
  logic [2:0]           trip_reg [2];
  // Bus side strobes.
  hps_wr_t              wr_reg;
  logic                 wr_stb_reg;
  logic [2:0]           cmd_reg;
  logic                 rd_stb_reg;

  // Effective enables, forcing and live conditions per slot.
  logic [1:0] aux_en;
  logic [1:0] main_en;
  logic [1:0] forced;
  logic [2:0] trip_set [2];
  logic [1:0] summary;
  logic       uv_live;
  logic       any_trip;
  logic       any_flag;

  always_comb begin
    uv_live  = 1'b0;
    any_trip = 1'b0;
    any_flag = uv_flag_reg | ot_flag_reg;
    for (int s = 0; s < 2; s++) begin
      // Direct mode follows pins, bus mode follows control bits.
      aux_en[s]  = smbus_mode_reg ? ctrl_reg[s][`HPS_CT_AUXEN]
                                  : apin_s[s];
      main_en[s] = smbus_mode_reg ? ctrl_reg[s][`HPS_CT_MAINEN]
                                  : mpin_s[s];
      forced[s]  = !fon_n_s[s] && !ctrl_reg[s][`HPS_CT_INHIB];
      trip_set[s] = {aux_en[s] && cond_s[s].aux_oc,
                     main_en[s] && cond_s[s].rail_twelve_oc,
                     main_en[s] && cond_s[s].rail_three_oc};
      summary[s] = |flag_reg[s] && !smbus_mode_reg;
      uv_live    = uv_live | (main_en[s] && cond_s[s].main_uv);
      any_trip   = any_trip | (|trip_reg[s]);
      any_flag   = any_flag | (|flag_reg[s]);
    end
  end

  // Trips latch while the enable is on; turning it off removes the fault.
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      trip_reg[0] <= '0;
      trip_reg[1] <= '0;
    end else if (ce) begin
      for (int s = 0; s < 2; s++) begin
        trip_reg[s][2]   <= aux_en[s] && (trip_reg[s][2] || trip_set[s][2]);
        trip_reg[s][1:0] <= main_en[s] ? (trip_reg[s][1:0] | trip_set[s][1:0])
                                       : 2'b00;
      end
    end
  end

  // Slot output switching; the die limit beats everything, forced or not.
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      aux_on         <= '0;
      main_on        <= '0;
      slot_fault_n   <= '1;
      power_good_out <= '0;
    end else if (ce) begin
      for (int s = 0; s < 2; s++) begin
        aux_on[s]  <= !t2_s && !cond_s[s].aux_supply_uv &&
                      (forced[s] || (aux_en[s] && !trip_reg[s][2]));
        main_on[s] <= !t2_s && (forced[s] || (main_en[s] &&
                      !(|trip_reg[s][1:0]) && !cond_s[s].aux_supply_uv));
        // Forced slots report neither fault nor power good.
        slot_fault_n[s]   <= forced[s] || !(|trip_reg[s]);
        power_good_out[s] <= !forced[s] && main_on[s] &&
                             cond_s[s].main_pg;
      end
    end
  end

  // Interrupt: live faults in direct mode, sticky flags under the mask.
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      irq_n <= 1'b1;
    end else if (ce) begin
      if (smbus_mode_reg) begin
        irq_n <= !(any_flag && !mask_reg);
      end else begin
        irq_n <= !(any_trip || uv_live || t2_s);
      end
    end
  end

  // Mode, control, mask and function registers.
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      smbus_mode_reg <= 1'b0;
      ctrl_reg[0]    <= '0;
      ctrl_reg[1]    <= '0;
      mask_reg       <= 1'b0;
      func_reg       <= `HPS_FN_RESET;
    end else if (ce && wr_stb_reg) begin
      unique case (wr_reg.cmd)
        `HPS_REG_CTRL_A, `HPS_REG_CTRL_B: begin
          ctrl_reg[wr_reg.cmd[0]] <= wr_reg.data[2:0];
          smbus_mode_reg          <= 1'b1;
        end
        `HPS_REG_COMMON: mask_reg <= wr_reg.data[`HPS_CS_MASK];
        `HPS_REG_FUNC: begin
          func_reg <= (wr_reg.data & `HPS_FN_WMASK) |
                      (`HPS_FN_RESET & ~`HPS_FN_WMASK);
        end
        default: ;
      endcase
    end
  end

  assign aux_ilim_sel  = func_reg[7:6];
  assign main_ilim_sel = func_reg[3:2];

  // Sticky flags: written ones arm a clear that the next read performs
  // only where the fault has gone; a new set always wins.
  logic [2:0] st_clr [2];
  logic [1:0] cs_clr;
  always_comb begin
    for (int s = 0; s < 2; s++) begin
      st_clr[s] = (rd_stb_reg && cmd_reg == (`HPS_REG_STAT_A | 3'(s)))
                  ? (echo_st_reg[s] & ~trip_reg[s]) : 3'b000;
    end
    cs_clr = (rd_stb_reg && cmd_reg == `HPS_REG_COMMON)
             ? (echo_cs_reg & ~{uv_live, t2_s}) : 2'b00;
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      flag_reg[0]    <= '0;
      flag_reg[1]    <= '0;
      echo_st_reg[0] <= '0;
      echo_st_reg[1] <= '0;
      uv_flag_reg    <= 1'b0;
      ot_flag_reg    <= 1'b0;
      echo_cs_reg    <= '0;
    end else if (ce) begin
      for (int s = 0; s < 2; s++) begin
        flag_reg[s] <= trip_reg[s] | (flag_reg[s] & ~st_clr[s]);
        if (rd_stb_reg && cmd_reg == (`HPS_REG_STAT_A | 3'(s))) begin
          echo_st_reg[s] <= '0;
        end else if (wr_stb_reg &&
                     wr_reg.cmd == (`HPS_REG_STAT_A | 3'(s))) begin
          echo_st_reg[s] <= echo_st_reg[s] | {wr_reg.data[`HPS_ST_AUXF],
                            wr_reg.data[`HPS_ST_12F],
                            wr_reg.data[`HPS_ST_3F]};
        end
      end
      uv_flag_reg <= uv_live | (uv_flag_reg & ~cs_clr[1]);
      ot_flag_reg <= t2_s | (ot_flag_reg & ~cs_clr[0]);
      if (rd_stb_reg && cmd_reg == `HPS_REG_COMMON) begin
        echo_cs_reg <= '0;
      end else if (wr_stb_reg && wr_reg.cmd == `HPS_REG_COMMON) begin
        echo_cs_reg <= echo_cs_reg | {wr_reg.data[`HPS_CS_UV],
                                      wr_reg.data[`HPS_CS_OT]};
      end
    end
  end

  // Read value of the selected register; reserved bits read zero except function bit 0, which reads one.
  logic [7:0] rd_val;
  always_comb begin
    rd_val = 8'h00;
    unique case (cmd_reg)
      `HPS_REG_CTRL_A, `HPS_REG_CTRL_B: begin
        rd_val[2:0] = ctrl_reg[cmd_reg[0]];
        rd_val[`HPS_CT_AUXPG]  = aux_en[cmd_reg[0]] &&
                                 cond_s[cmd_reg[0]].aux_pg;
        rd_val[`HPS_CT_MAINPG] = main_en[cmd_reg[0]] &&
                                 cond_s[cmd_reg[0]].main_pg;
      end
      `HPS_REG_STAT_A, `HPS_REG_STAT_B: begin
        rd_val[`HPS_ST_SUM]  = summary[cmd_reg[0]];
        rd_val[`HPS_ST_MAIN] = main_on[cmd_reg[0]];
        rd_val[`HPS_ST_AUX]  = aux_on[cmd_reg[0]];
        rd_val[`HPS_ST_AUXF] = flag_reg[cmd_reg[0]][2];
        rd_val[`HPS_ST_12F]  = flag_reg[cmd_reg[0]][1];
        rd_val[`HPS_ST_3F]   = flag_reg[cmd_reg[0]][0];
      end
      `HPS_REG_COMMON: begin
        rd_val[`HPS_CS_GPI_HI:`HPS_CS_GPI_LO] = gpi_dg;
        rd_val[`HPS_CS_MASK] = mask_reg;
        rd_val[`HPS_CS_UV]   = uv_flag_reg;
        rd_val[`HPS_CS_OT]   = ot_flag_reg;
      end
      `HPS_REG_FUNC: begin
        rd_val = func_reg;
        rd_val[`HPS_FN_SAFE_B] = cond_s[1].below_low;
        rd_val[`HPS_FN_SAFE_A] = cond_s[0].below_low;
      end
      default: rd_val = 8'h00;
    endcase
  end

  // Serial bus edges and conditions, seen on the synchronised copies.
  logic scl_d_reg;
  logic sda_d_reg;
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;
  logic [7:0] nb;

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end else if (ce) begin
      scl_d_reg <= scl_s;
      sda_d_reg <= sda_s;
    end
  end

  assign scl_rise  = scl_s && !scl_d_reg;
  assign scl_fall  = !scl_s && scl_d_reg;
  assign bus_start = scl_s && scl_d_reg && sda_d_reg && !sda_s;
  assign bus_stop  = scl_s && scl_d_reg && !sda_d_reg && sda_s;

  // Serial slave: address, command, then write data or read data bytes.
  hps_bus_state_t state_reg;
  hps_bus_state_t after_reg;
  logic [7:0]     shift_reg;
  logic [2:0]     cnt_reg;
  logic           ack_reg;
  logic           phase_reg;

  assign nb = {shift_reg[6:0], sda_s};

  // SDA changes a few mclk after SCL falls, inside the low phase.
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      state_reg  <= S_IDLE;
      after_reg  <= S_IDLE;
      shift_reg  <= '0;
      cnt_reg    <= '0;
      ack_reg    <= 1'b0;
      phase_reg  <= 1'b0;
      cmd_reg    <= '0;
      wr_reg     <= '0;
      wr_stb_reg <= 1'b0;
      rd_stb_reg <= 1'b0;
      sda_oe     <= 1'b0;
      sda_o      <= 1'b0;
    end else if (ce) begin
      wr_stb_reg <= 1'b0;
      rd_stb_reg <= 1'b0;
      if (bus_start) begin
        state_reg <= S_ADDR;
        cnt_reg   <= '0;
        sda_oe    <= 1'b0;
      end else if (bus_stop) begin
        state_reg <= S_IDLE;
        sda_oe    <= 1'b0;
      end else begin
        unique case (state_reg)
          S_IDLE: ;
          S_ADDR, S_CMD, S_WDATA: begin
            if (scl_rise) begin
              shift_reg <= nb;
              cnt_reg   <= cnt_reg + 3'h1;
              if (cnt_reg == 3'h7) begin
                state_reg <= S_ACK;
                phase_reg <= 1'b0;
                unique case (state_reg)
                  S_ADDR: begin
                    ack_reg   <= nb[7:1] == {`HPS_ADDR_HI, straps_s};
                    after_reg <= nb[0] ? S_TX : S_CMD;
                  end
                  S_CMD: begin
                    ack_reg   <= nb[7:3] == 5'h00;
                    cmd_reg   <= nb[2:0];
                    after_reg <= S_WDATA;
                  end
                  default: begin
                    ack_reg    <= 1'b1;
                    wr_reg     <= '{cmd: cmd_reg, data: nb};
                    wr_stb_reg <= 1'b1;
                    after_reg  <= S_WDATA;
                  end
                endcase
              end
            end
          end
          S_ACK: begin
            if (scl_fall && !phase_reg) begin
              sda_oe    <= ack_reg;
              phase_reg <= 1'b1;
            end else if (scl_fall) begin
              state_reg <= ack_reg ? after_reg : S_IDLE;
              cnt_reg   <= '0;
              if (ack_reg && after_reg == S_TX) begin
                shift_reg  <= rd_val;
                sda_oe     <= !rd_val[7];
                rd_stb_reg <= 1'b1;
              end else begin
                sda_oe <= 1'b0;
              end
            end
          end
          S_TX: begin
            if (scl_fall) begin
              if (cnt_reg == 3'h7) begin
                sda_oe    <= 1'b0;
                state_reg <= S_RACK;
              end else begin
                shift_reg <= {shift_reg[6:0], 1'b0};
                sda_oe    <= !shift_reg[6];
                cnt_reg   <= cnt_reg + 3'h1;
              end
            end
          end
          S_RACK: begin
            // A master acknowledge asks for the same register again.
            if (scl_rise) begin
              state_reg <= sda_s ? S_IDLE : S_ACK;
              phase_reg <= 1'b1;
              ack_reg   <= 1'b1;
              after_reg <= S_TX;
            end
          end
          default: state_reg <= S_IDLE;
        endcase
      end
    end
  end

  // Checks next to the logic they guard.
  AST_MODE_STICKY: assert property (@(posedge mclk) disable iff (!resetn)
    smbus_mode_reg |=> smbus_mode_reg) else $error("mode fell back");
  AST_FUNC_NO_SWITCH: assert property (@(posedge mclk) disable iff (!resetn)
    ce && wr_stb_reg && wr_reg.cmd == `HPS_REG_FUNC && !smbus_mode_reg
    |=> !smbus_mode_reg) else $error("function write changed mode");
  AST_MASK_QUIET: assert property (@(posedge mclk) disable iff (!resetn)
    ce && smbus_mode_reg && mask_reg |=> irq_n)
    else $error("masked interrupt asserted");
  AST_DIRECT_IRQ: assert property (@(posedge mclk) disable iff (!resetn)
    ce && !smbus_mode_reg && (any_trip || t2_s) |=> !irq_n)
    else $error("fault without interrupt");
  AST_FORCE_HIDES: assert property (@(posedge mclk) disable iff (!resetn)
    ce && forced[0] |=> slot_fault_n[0] && !power_good_out[0])
    else $error("forced slot shows status");
  AST_FORCE_ON: assert property (@(posedge mclk) disable iff (!resetn)
    ce && forced[1] && !t2_s && !cond_s[1].aux_supply_uv
    |=> aux_on[1] && main_on[1]) else $error("forced slot not on");
  AST_T2_OFF: assert property (@(posedge mclk) disable iff (!resetn)
    ce && t2_s |=> aux_on == 2'b00 && main_on == 2'b00)
    else $error("outputs on at thermal level two");
  AST_AUX_UV_OFF: assert property (@(posedge mclk) disable iff (!resetn)
    ce && cond_s[0].aux_supply_uv |=> !aux_on[0])
    else $error("aux on under supply undervoltage");
  AST_FLAG_STICKY: assert property (@(posedge mclk) disable iff (!resetn)
    flag_reg[0][2] && !rd_stb_reg |=> flag_reg[0][2])
    else $error("flag cleared without read");

endmodule
`default_nettype wire

/* File: testbench/hps_host.sv */
// Behavioural bus host issuing write-byte and read-byte transfers.
`timescale 1ns/100ps
`default_nettype none
module hps_host #(
  parameter logic [6:0] ADDR = 7'h45
) (
  // Bus lines, data is open drain with a pull-up
  output logic      scl,
  output logic      sda_d,
  input  wire logic sda
);
  int nak = 0;
  initial begin
    scl = 1'b1;
    sda_d = 1'b1;
  end
  // Data moves in the low phase and is sampled midway through the high phase.
  task automatic bitx(input logic b, output logic r);
    sda_d = b;
    #31 scl = 1'b1;
    #31 r = sda;
    #32 scl = 1'b0;
    #31;
  endtask
  // Start and repeated start share one shape.
  task automatic st();
    sda_d = 1'b1;
    #31 scl = 1'b1;
    #31 sda_d = 1'b0;
    #31 scl = 1'b0;
    #31;
  endtask
  task automatic sp();
    sda_d = 1'b0;
    #31 scl = 1'b1;
    #31 sda_d = 1'b1;
    #62;
  endtask
  // A missing acknowledge is counted and judged by the bench.
  task automatic tx(input logic [7:0] v);
    logic r;
    for (int i = 7; i >= 0; i--) bitx(v[i], r);
    bitx(1'b1, r);
    if (r !== 1'b0) nak++;
  endtask
  task automatic rx(output logic [7:0] v);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bitx(1'b1, r);
      v[i] = r;
    end
    bitx(1'b1, r);
  endtask
  task automatic wr(input logic [2:0] c, input logic [7:0] d);
    st();
    tx({ADDR, 1'b0});
    tx({5'h00, c});
    tx(d);
    sp();
  endtask
  task automatic rd(input logic [2:0] c, output logic [7:0] v);
    st();
    tx({ADDR, 1'b0});
    tx({5'h00, c});
    st();
    tx({ADDR, 1'b1});
    rx(v);
    sp();
  endtask
endmodule
`default_nettype wire

/* File: testbench/testbench.sv */
// Self-checking bench for the dual slot controller.
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import hps_pkg::*;
  logic mclk, resetn, scl, sda_d, sda_o, sda_oe, irq_n, t2;
  logic [1:0] mp, ae, fo, aon, mon, fn, pg, ai, mi;
  logic [3:0] gi;
  logic [7:0] d;
  hps_slot_cond_t [1:0] sc;
  int fails = 0;
  int checks = 0;
  wire logic sda = sda_d & ~(sda_oe & ~sda_o);
  hps_host i_hps_host (.scl(scl), .sda_d(sda_d), .sda(sda));
  hps_ctrl #(.DGL_CYCLES(20)) i_hps_ctrl (.mclk(mclk), .resetn(resetn),
    .ce(1'b1), .scl(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe),
    .address_straps(3'h5), .main_power_pin(mp), .aux_enable_pin(ae),
    .force_on_n(fo), .general_input(gi), .slot_cond(sc),
    .thermal_level_two(t2), .aux_on(aon), .main_on(mon),
    .slot_fault_n(fn), .power_good_out(pg), .aux_ilim_sel(ai),
    .main_ilim_sel(mi), .irq_n(irq_n));
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  task automatic w(int n);
    repeat (n) @(negedge mclk);
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    checks++;
    if (g !== e) begin
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
      fails++;
    end
  endtask
  task automatic conclude();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Direct mode: pins switch outputs, trips latch until the pin drops.
  task automatic s_direct();
    i_hps_host.rd(3'h7, d);
    chk(d, 8'h0d);
    i_hps_host.wr(3'h7, 8'h00);
    chk({ai, mi}, 4'h0);
    mp = 2'b01;
    ae = 2'b01;
    w(6);
    chk({mon[0], aon[0], irq_n}, 3'h7);
    sc[0].rail_twelve_oc = 1'b1;
    w(6);
    chk({irq_n, fn[0]}, 2'b00);
    sc[0].rail_twelve_oc = 1'b0;
    i_hps_host.rd(3'h4, d);
    chk(d & 8'h95, 8'h84);
    mp = 2'b00;
    ae = 2'b00;
    w(6);
    chk(irq_n, 1'b1);
  endtask
  // Force-on overrides enables, hides status, yields to level two heat.
  task automatic s_force();
    sc[1].main_pg = 1'b1;
    sc[0].aux_supply_uv = 1'b1;
    fo = 2'b00;
    w(6);
    chk({aon[1], mon[1], pg[1], fn[1]}, 4'hd);
    chk({aon[0], mon[0], fn[0]}, 3'h3);
    t2 = 1'b1;
    w(6);
    chk({aon[1], mon[1], irq_n}, 3'h0);
    t2 = 1'b0;
    sc[0].aux_supply_uv = 1'b0;
    fo = 2'b11;
  endtask
  // Bus mode: sticky flags, echo reset, inhibit and mask.
  task automatic s_bus();
    i_hps_host.wr(3'h2, 8'h04);
    fo = 2'b10;
    w(6);
    chk(aon[0], 1'b0);
    fo = 2'b11;
    i_hps_host.wr(3'h2, 8'h03);
    w(6);
    chk({mon[0], aon[0]}, 2'b11);
    i_hps_host.wr(3'h4, 8'h04);
    i_hps_host.rd(3'h4, d);
    chk(d & 8'h95, 8'h04);
    i_hps_host.wr(3'h6, 8'h02);
    i_hps_host.rd(3'h6, d);
    chk(d & 8'h0e, 8'h02);
    w(6);
    chk(irq_n, 1'b1);
    sc[0].aux_oc = 1'b1;
    w(6);
    chk(irq_n, 1'b0);
    i_hps_host.wr(3'h2, 8'h02);
    sc[0].aux_oc = 1'b0;
    i_hps_host.rd(3'h4, d);
    chk(d & 8'h95, 8'h10);
    i_hps_host.wr(3'h4, 8'h10);
    i_hps_host.rd(3'h4, d);
    chk(d & 8'h10, 8'h10);
    i_hps_host.rd(3'h4, d);
    chk({d[4], irq_n}, 2'b01);
    i_hps_host.wr(3'h6, 8'h08);
    t2 = 1'b1;
    w(6);
    chk(irq_n, 1'b1);
    t2 = 1'b0;
    i_hps_host.rd(3'h6, d);
    chk(d & 8'h0e, 8'h0a);
  endtask
  // Deglitched inputs and the safe removal bits read back.
  task automatic s_inputs();
    gi = 4'h5;
    sc[1].below_low = 1'b1;
    w(40);
    i_hps_host.rd(3'h6, d);
    chk(d[7:4], 4'h5);
    i_hps_host.rd(3'h7, d);
    chk(d[5:4], 2'b10);
  endtask
  initial begin
    resetn = 1'b0;
    {mp, ae, gi, t2} = 9'h000;
    fo = 2'b11;
    sc = '0;
    w(2);
    resetn = 1'b1;
    w(4);
    s_direct();
    s_force();
    s_bus();
    s_inputs();
    chk(i_hps_host.nak[7:0], 8'h00);
    conclude();
  end
  // Cuts a hang short.
  initial begin
    #400000;
    fails++;
    conclude();
  end
endmodule
`default_nettype wire
